// ===== rtl/pm_fence.sv
// Per-port power states, D3hot filtering, PM_PME retry and turn-off fence
//
// Contract
// R1: Downstream bridge state affects only its port
// R2: D3hot port seeks L1 regardless of others
// R3: Upstream D3hot plus acks puts switch low
// R4: Four device states per bridge
// R5: D3hot to D0 keeps context, flag says so
// R6: Reset gives D0 uninit, configure gives active
// R7: D3 write from active, D0 write from D3hot
// R8: D3hot accepts type 0 configuration requests
// R9: D3hot accepts messages aimed at bridge
// R10: D3hot other primary requests get UR
// R11: D3hot reports TLP errors, drops others
// R12: D3hot own completions unexpected, through routed
// R13: D3hot secondary requests get UR
// R14: No PME from D3cold, PME from D3hot
// R15: Resend PM_PME while pending after timeout
// R16: Turn-off forwarded on every active downstream port
// R17: Ack upstream and L2/L3 after all acks
// R18: Upstream TLP abandons aggregation; later drops allowed
// R19: Aborting TLP handled locally or forwarded, retrained
// R20: Downstream handshake continues; traffic wakes link
// R21: Ack timeout counts as ack, link L2/L3
// R22: Back to D0 uninit resumes PM_PME
// R23: Timers use fixed base, load timeout on start
`timescale 1ns/10ps
`default_nettype none
module pm_fence
    import pm_fence_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    input  wire tlp_in_s [NP-1:0]    tlp_in,
    output verdict_s [NP-1:0]        verdict_out,
    input  wire logic [NP-1:0]       err_event,
    input  wire logic [NP-1:0]       err_from_tlp,
    output logic [NP-1:0]            err_msg,
    input  wire logic [NP-1:0]       hp_event,
    output logic [NP-1:0]            pme_send,
    output logic [NP-1:0]            link_l1_req,
    input  wire logic                rx_turnoff,
    input  wire logic [NP-1:0]       ds_active,
    output logic [NP-1:0]            tx_turnoff,
    input  wire logic [NP-1:0]       rx_to_ack,
    output logic [NP-1:0]            ack_timeout,
    output logic [NP-1:0]            link_l23_req,
    output logic                     tx_to_ack,
    output logic                     up_l23_req,
    input  wire up_tlp_s             up_tlp,
    output logic                     up_tlp_local,
    output logic                     up_tlp_drop,
    input  wire logic [NP-1:0]       link_in_l0,
    output logic [NP-1:0]            retrain_req,
    output logic [NP-1:0]            fwd_tlp,
    input  wire logic                power_off,
    output logic                     dev_low_power
);
    // ****************************************
    // Register bus
    // ****************************************
    logic [7:0]    wr_addr;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;
    logic          wr_fire;
    logic          wr_ok;
    logic [PW-1:0] wr_port;
    logic          rd_ok;
    logic [PW-1:0] rd_port;
    logic [31:0]   next_rdata;

    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_ok   = wr_addr < MAP_END;
    assign wr_port = wr_addr[6:4];
    assign rd_ok   = s_axi_araddr < MAP_END;
    assign rd_port = s_axi_araddr[6:4];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb       <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                wr_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // Time base
    // ****************************************
    logic [8:0] tick_cnt;
    logic       tick;

    always_ff @(posedge core_clk)
    begin
        if (rst || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 9'h001;
    end
    assign tick = tick_cnt == 9'(TICK_CYC - 1);  // see R23

    // ****************************************
    // Fence sequencer
    // ****************************************
    fence_e        fence;
    dstate_e       dstate [NP];
    logic [NP-1:0] ack_pend;
    logic [NP-1:0] ack_done;
    logic [NP-1:0] woke;
    logic [NP-1:0] fwd_need;
    logic [NP-1:0] fwd_wait;
    logic [NP-1:0] ds_mask;
    logic [31:0]   port_rd [NP];
    logic          abandon;

    assign ds_mask    = {{(NP-1){1'b1}}, 1'b0};
    assign abandon    = fence == F_AGGR && up_tlp.valid;  // see R18
    assign next_rdata = rd_ok ? port_rd[rd_port] : 32'h0000_0000;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            fence <= F_IDLE;
        else
        begin
            unique case (fence)
                F_IDLE:
                    if (rx_turnoff)
                        fence <= F_AGGR;
                F_AGGR:
                    if (abandon)
                        fence <= F_IDLE;  // see R18
                    else if (ack_pend == '0 && !(|tx_turnoff))
                        fence <= F_DONE;  // see R17
                F_DONE:
                    if (woke[0])
                        fence <= F_IDLE;  // see R22
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tx_turnoff    <= '0;
            tx_to_ack     <= 1'b0;
            up_l23_req    <= 1'b0;
            dev_low_power <= 1'b0;
        end
        else
        begin
            tx_turnoff <= '0;
            tx_to_ack  <= 1'b0;
            if (fence == F_IDLE && rx_turnoff)
                tx_turnoff <= ds_active & ds_mask;  // see R16
            if (fence == F_AGGR && !abandon && ack_pend == '0 && !(|tx_turnoff))
            begin
                tx_to_ack  <= 1'b1;  // see R17
                up_l23_req <= 1'b1;
            end
            else if (fence != F_DONE)
                up_l23_req <= 1'b0;
            dev_low_power <= dstate[0] == D3_HOT && fence == F_DONE;  // see R3
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            up_tlp_local <= 1'b0;
            up_tlp_drop  <= 1'b0;
        end
        else
        begin
            up_tlp_drop  <= up_tlp.valid && fence == F_DONE;  // see R18
            up_tlp_local <= up_tlp.valid && fence != F_DONE
                            && up_tlp.target == '0;  // see R19
        end
    end

    // ****************************************
    // Per-port logic
    // ****************************************
    for (genvar p = 0; p < NP; p++)
    begin : g_port
        logic          sel_wr;
        logic          is_d3;
        logic          pme_en;
        logic          pme_pend;
        logic          pme_sent;
        logic          pme_fire;
        logic          pme_exp;
        logic          ack_exp;
        logic [TW-1:0] pme_tmo;
        logic [TW-1:0] ack_tmo;

        assign sel_wr  = wr_fire && wr_ok && wr_port == PW'(p);
        assign is_d3   = dstate[p] == D3_HOT;
        assign woke[p] = sel_wr && wr_addr[3:0] == OFF_CTRL && wr_strb[0]
                         && wr_data[PS_LSB +: 2] == PS_D0 && is_d3;
        assign fwd_need[p] = up_tlp.valid && fence != F_DONE && p != 0
                             && up_tlp.target == PW'(p);
        assign ack_done[p] = rx_to_ack[p] || ack_exp;
        assign pme_fire = p != 0 && pme_pend && pme_en && dstate[p] != D3_COLD
                          && (!pme_sent || pme_exp);  // see R14 R15 R22
        always_ff @(posedge core_clk)
        begin
            if (rst)
                dstate[p] <= D0_UNINIT;  // see R6 R4
            else if (power_off && fence == F_DONE)
                dstate[p] <= D3_COLD;
            else if (sel_wr && wr_addr[3:0] == OFF_CTRL)
            begin
                if (wr_strb[0] && wr_data[PS_LSB +: 2] == PS_D3 && dstate[p] == D0_ACTIVE)
                    dstate[p] <= D3_HOT;  // see R7 R1
                else if (woke[p])
                    dstate[p] <= D0_UNINIT;  // see R7 R5
                else if (wr_strb[2] && wr_data[CFG_DONE_BIT] && dstate[p] == D0_UNINIT)
                    dstate[p] <= D0_ACTIVE;  // see R6
            end
        end
        always_ff @(posedge core_clk)
        begin
            if (rst)
            begin
                pme_en  <= 1'b0;
                pme_tmo <= PME_TMO_RST;
                ack_tmo <= ACK_TMO_RST;
            end
            else if (sel_wr)
            begin
                if (wr_addr[3:0] == OFF_CTRL && wr_strb[1])
                    pme_en <= wr_data[PME_EN_BIT];
                if (wr_addr[3:0] == OFF_PME_TMR && wr_strb[1:0] == 2'b11)
                    pme_tmo <= wr_data[TW-1:0];
                if (wr_addr[3:0] == OFF_ACK_TMR && wr_strb[1:0] == 2'b11)
                    ack_tmo <= wr_data[TW-1:0];
            end
        end

        // Pending flag: event set wins over write-one clear
        always_ff @(posedge core_clk)
        begin
            if (rst)
            begin
                pme_pend    <= 1'b0;
                pme_sent    <= 1'b0;
                pme_send[p] <= 1'b0;
            end
            else
            begin
                if (hp_event[p] && p != 0)
                    pme_pend <= 1'b1;
                else if (sel_wr && wr_addr[3:0] == OFF_CTRL && wr_strb[1]
                         && wr_data[PME_PEND_BIT])
                    pme_pend <= 1'b0;
                pme_send[p] <= pme_fire;  // see R15
                if (pme_fire)
                    pme_sent <= 1'b1;
                else if (!pme_pend || dstate[p] == D3_COLD)
                    pme_sent <= 1'b0;
            end
        end
        pm_tick_timer u_pme_timer (
            .core_clk (core_clk),
            .rst      (rst),
            .tick     (tick),
            .start    (pme_fire),
            .stop     (!pme_pend),
            .load     (pme_tmo),
            .expired  (pme_exp)
        );  // see R23
        pm_tick_timer u_ack_timer (
            .core_clk (core_clk),
            .rst      (rst),
            .tick     (tick),
            .start    (tx_turnoff[p]),
            .stop     (rx_to_ack[p]),
            .load     (ack_tmo),
            .expired  (ack_exp)
        );  // see R23 R21
        always_ff @(posedge core_clk)
        begin
            if (rst)
            begin
                ack_pend[p]     <= 1'b0;
                ack_timeout[p]  <= 1'b0;
                link_l23_req[p] <= 1'b0;
            end
            else
            begin
                ack_timeout[p] <= ack_exp && ack_pend[p];  // see R21
                if (tx_turnoff[p])
                    ack_pend[p] <= 1'b1;
                else if (ack_done[p])
                    ack_pend[p] <= 1'b0;  // see R17 R21 R20
                if (ack_done[p] && ack_pend[p])
                    link_l23_req[p] <= 1'b1;  // see R20 R21
                else if (fwd_wait[p] && link_in_l0[p])
                    link_l23_req[p] <= 1'b0;
            end
        end
        always_ff @(posedge core_clk)
        begin
            if (rst)
            begin
                fwd_wait[p]    <= 1'b0;
                fwd_tlp[p]     <= 1'b0;
                retrain_req[p] <= 1'b0;
            end
            else
            begin
                fwd_tlp[p]     <= 1'b0;
                retrain_req[p] <= 1'b0;
                if (fwd_need[p] && link_in_l0[p] && !fwd_wait[p])
                    fwd_tlp[p] <= 1'b1;  // see R19
                else if (fwd_need[p] && !fwd_wait[p])
                begin
                    fwd_wait[p]    <= 1'b1;
                    retrain_req[p] <= 1'b1;  // see R19 R20
                end
                else if (fwd_wait[p] && link_in_l0[p])
                begin
                    fwd_wait[p] <= 1'b0;
                    fwd_tlp[p]  <= 1'b1;
                end
            end
        end
        always_ff @(posedge core_clk)
        begin
            if (rst)
            begin
                verdict_out[p] <= '0;
                err_msg[p]     <= 1'b0;
                link_l1_req[p] <= 1'b0;
            end
            else
            begin
                link_l1_req[p]       <= is_d3;  // see R1 R2
                err_msg[p]           <= err_event[p] && (err_from_tlp[p] || !is_d3);  // see R11
                verdict_out[p].valid <= tlp_in[p].valid;
                if (tlp_in[p].kind == K_CPL_THRU)
                    verdict_out[p].verdict <= V_ROUTE;  // see R12
                else if (tlp_in[p].kind == K_CPL_SELF)
                    verdict_out[p].verdict <= is_d3 ? V_UC : V_ACCEPT;  // see R12
                else if (tlp_in[p].secondary)
                    verdict_out[p].verdict <= is_d3 ? V_UR : V_ROUTE;  // see R13
                else if (tlp_in[p].kind == K_CFG0 || tlp_in[p].kind == K_MSG_SELF)
                    verdict_out[p].verdict <= V_ACCEPT;  // see R8 R9
                else
                    verdict_out[p].verdict <= is_d3 ? V_UR : V_ROUTE;  // see R10
            end
        end
        always_comb
        begin
            port_rd[p] = 32'h0000_0000;
            unique case (s_axi_araddr[3:0])
                OFF_CTRL:
                begin
                    port_rd[p][PS_LSB +: 2]   = is_d3 ? PS_D3 : PS_D0;
                    port_rd[p][CTX_BIT]       = 1'b1;  // see R5
                    port_rd[p][PME_EN_BIT]    = pme_en;
                    port_rd[p][PME_PEND_BIT]  = pme_pend;
                end
                OFF_PME_TMR: port_rd[p][TW-1:0] = pme_tmo;
                OFF_ACK_TMR: port_rd[p][TW-1:0] = ack_tmo;
                OFF_STATUS:
                begin
                    port_rd[p][1:0]              = dstate[p];
                    port_rd[p][ST_L23_BIT]       = link_l23_req[p];
                    port_rd[p][ST_PEND_BIT]      = ack_pend[p];
                    port_rd[p][ST_FSM_LSB +: 2]  = fence;
                    port_rd[p][ST_FWD_BIT]       = fwd_wait[p];
                end
                default: port_rd[p] = 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== rtl/pm_fence_pkg.sv
// Constants, types and register map of the switch power management fence
package pm_fence_pkg;
    // Ports: index 0 faces the root complex, 1 to NP-1 face link partners
    localparam int NP = 6;
    localparam int PW = 3;
    localparam int TW = 16;

    // Register map, one block of four words per port
    localparam logic [7:0] MAP_END      = 8'h60;
    localparam logic [3:0] OFF_CTRL     = 4'h0;
    localparam logic [3:0] OFF_PME_TMR  = 4'h4;
    localparam logic [3:0] OFF_ACK_TMR  = 4'h8;
    localparam logic [3:0] OFF_STATUS   = 4'hC;

    localparam int PS_LSB       = 0;
    localparam int CTX_BIT      = 3;
    localparam int PME_EN_BIT   = 8;
    localparam int PME_PEND_BIT = 15;
    localparam int CFG_DONE_BIT = 16;
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D3 = 2'h3;

    localparam int ST_L23_BIT  = 2;
    localparam int ST_PEND_BIT = 3;
    localparam int ST_FSM_LSB  = 4;
    localparam int ST_FWD_BIT  = 6;

    localparam logic [TW-1:0] PME_TMO_RST = 16'h0064;
    localparam logic [TW-1:0] ACK_TMO_RST = 16'h0064;

    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        D0_UNINIT = 2'b00,
        D0_ACTIVE = 2'b01,
        D3_HOT    = 2'b10,
        D3_COLD   = 2'b11
    } dstate_e;

    typedef enum logic [1:0] {
        F_IDLE = 2'b00,
        F_AGGR = 2'b01,
        F_DONE = 2'b10
    } fence_e;

    typedef enum logic [2:0] {
        K_CFG0      = 3'b000,
        K_MSG_SELF  = 3'b001,
        K_REQ_OTHER = 3'b010,
        K_CPL_SELF  = 3'b011,
        K_CPL_THRU  = 3'b100
    } tlp_kind_e;

    typedef enum logic [1:0] {
        V_ACCEPT = 2'b00,
        V_UR     = 2'b01,
        V_UC     = 2'b10,
        V_ROUTE  = 2'b11
    } verdict_e;

    typedef struct packed {
        logic      valid;
        logic      secondary;
        tlp_kind_e kind;
    } tlp_in_s;

    typedef struct packed {
        logic     valid;
        verdict_e verdict;
    } verdict_s;

    typedef struct packed {
        logic          valid;
        logic [PW-1:0] target;
    } up_tlp_s;
endpackage

// ===== rtl/pm_tick_timer.sv
// Tick based countdown timer with load on start
`timescale 1ns/10ps
`default_nettype none
module pm_tick_timer
    import pm_fence_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          tick,
    input  wire logic          start,
    input  wire logic          stop,
    input  wire logic [TW-1:0] load,
    output logic               expired
);
    logic [TW-1:0] count;
    logic          running;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            count   <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end
        else
        begin
            expired <= 1'b0;
            if (start)
            begin
                count   <= load;
                running <= 1'b1;
            end
            else if (stop)
                running <= 1'b0;
            else if (running && tick)
            begin
                if (count <= 16'h0001)
                begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
                else
                    count <= count - 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/pm_fence_bench.sv
// Self-checking bench for the power management fence
`timescale 1ns/10ps
`default_nettype none
module pm_fence_bench import pm_fence_pkg::*;;
    logic core_clk = 0, rst = 1, rx_turnoff = 0, power_off = 0, slow = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    tlp_in_s [NP-1:0] tlp_in = '0;
    verdict_s [NP-1:0] verdict_out;
    up_tlp_s up_tlp = '0;
    logic [NP-1:0] err_event = 0, err_from_tlp = 0, hp_event = 0, ds_active = 6'h3E, mute = 0;
    logic [NP-1:0] err_msg, pme_send, link_l1_req, tx_turnoff, rx_to_ack, ack_timeout;
    logic [NP-1:0] link_l23_req, link_in_l0, retrain_req, fwd_tlp;
    logic tx_to_ack, up_l23_req, up_tlp_local, up_tlp_drop, dev_low_power;
    int num_errors = 0, cmp_count = 0, cyc = 0, pmc = 0, tto = 0, fwc = 0, ato = 0, i;
    verdict_e ev [5] = '{V_ACCEPT, V_ACCEPT, V_UR, V_UC, V_ROUTE};
    pm_fence dut_u (.*);
    pm_link_partner link_u (.*);
    always #2 core_clk = ~core_clk;
    // ****
    // Tasks
    // ****
    task automatic final_report;
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        pmc += pme_send[1];
        tto += tx_to_ack;
        fwc += fwd_tlp[3];
        ato += ack_timeout[5];
        if (cyc == 20000)
        begin
            num_errors++;
            final_report;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do
        begin
            tick(1);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        while (!s_axi_bvalid);
    endtask
    task automatic rck(input logic [7:0] a, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do
        begin
            tick(1);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end
        while (!s_axi_rvalid);
        chk($sformatf("reg %h", a), s_axi_rdata, e);
    endtask
    task automatic tlp(input logic s, input tlp_kind_e k, input verdict_e e);
        tlp_in[1] <= '{1'b1, s, k};
        tick(1);
        tlp_in[1] <= '0;
        tick(1);
        chk("verdict", verdict_out[1], {1'b1, e});
    endtask
    task automatic pulse(input int sel, input logic [2:0] t);
        if (sel == 0) hp_event[1] <= 1;
        if (sel == 1) rx_turnoff <= 1;
        if (sel == 2) up_tlp <= '{1'b1, t};
        tick(1);
        hp_event <= 0;
        rx_turnoff <= 0;
        up_tlp <= '0;
        tick(1);
    endtask
    // ****
    // Sequence
    // ****
    initial
    begin
        tick(12);
        rst <= 0;
        rck(8'h1C, 0);
        rck(8'h10, 32'h8);
        rck(8'h14, 32'h64);
        wr(8'h60, 0);
        rck(8'h60, 0);
        chk("resp", {s_axi_bresp, s_axi_rresp}, {RESP_SLVERR, RESP_SLVERR});
        wr(8'h10, 32'h10000);
        rck(8'h1C, 1);
        wr(8'h10, 3);
        rck(8'h1C, 2);
        rck(8'h10, 32'hB);
        chk("l1", link_l1_req, 6'h02);
        for (i = 0; i < 5; i++) tlp(0, tlp_kind_e'(i), ev[i]);
        tlp(1, K_REQ_OTHER, V_UR);
        for (i = 0; i < 2; i++)
        begin
            err_from_tlp[1] <= i[0];
            err_event[1] <= 1;
            tick(1);
            err_event[1] <= 0;
            tick(1);
            chk("err", err_msg[1], i);
        end
        wr(8'h14, 1);
        wr(8'h10, 32'h100, 4'h2);
        pulse(0, 0);
        tick(600);
        chk("resend", pmc >= 2, 1);
        wr(8'h10, 32'h8100, 4'h2);
        tick(2);
        i = pmc;
        tick(600);
        chk("stop", pmc, i);
        wr(8'h10, 0, 4'h1);
        rck(8'h1C, 0);
        rck(8'h14, 1);
        i = pmc;
        pulse(0, 0);
        tick(2);
        chk("resume", pmc, i + 1);
        pulse(1, 0);
        tick(3);
        pulse(2, 3'h0);
        chk("local", up_tlp_local, 1);
        tick(100);
        chk("abandon", tto, 0);
        pulse(2, 3'h3);
        chk("retrain", retrain_req, 6'h08);
        tick(20);
        chk("forward", fwc, 1);
        wr(8'h00, 32'h10000);
        wr(8'h00, 3);
        wr(8'h58, 1);
        mute <= 6'h20;
        slow <= 0;
        pulse(1, 0);
        while (tto == 0) tick(1);
        tick(2);
        chk("l23", link_l23_req[5], 1);
        chk("low", dev_low_power, 1);
        chk("timeout", ato, 1);
        pulse(2, 3'h2);
        chk("drop", up_tlp_drop, 1);
        power_off <= 1;
        i = pmc;
        pulse(0, 0);
        tick(2);
        chk("cold", pmc, i);
        final_report;
    end
endmodule
`default_nettype wire

// ===== verification/pm_fence_sva.sv
// Assertion checker for the power management fence
`timescale 1ns/10ps
`default_nettype none
module pm_fence_sva
    import pm_fence_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire tlp_in_s  [NP-1:0] tlp_in,
    input wire verdict_s [NP-1:0] verdict_out,
    input wire logic [NP-1:0]     err_event,
    input wire logic [NP-1:0]     err_msg,
    input wire logic              rx_turnoff,
    input wire logic [NP-1:0]     ds_active,
    input wire logic [NP-1:0]     tx_turnoff,
    input wire logic              tx_to_ack,
    input wire logic              up_l23_req,
    input wire logic              dev_low_power,
    input wire up_tlp_s           up_tlp,
    input wire logic              up_tlp_local,
    input wire logic              up_tlp_drop,
    input wire logic [NP-1:0]     link_in_l0,
    input wire logic [NP-1:0]     retrain_req
);
    // ****
    // Checks
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    turnoff_fwd_a:
        assert property (|tx_turnoff |-> $past(rx_turnoff)
            && (tx_turnoff & ~$past(ds_active)) == '0) else $error("stray turnoff");
    ack_up_a:
        assert property (tx_to_ack |-> up_l23_req) else $error("ack without l23");
    err_gate_a:
        assert property ((err_msg & ~$past(err_event)) == '0) else $error("stray error");
    verdict_lag_a:
        assert property (verdict_out[1].valid == $past(tlp_in[1].valid)) else $error("verdict");
    low_power_a:
        assert property (dev_low_power |-> $past(up_l23_req)) else $error("low power early");
    drop_done_a:
        assert property (up_tlp_drop |-> $past(up_tlp.valid) && up_l23_req) else $error("drop");
    local_tlp_a:
        assert property (up_tlp_local |-> $past(up_tlp.valid) && $past(up_tlp.target) == 3'h0)
            else $error("local");
    retrain_down_a:
        assert property ((retrain_req & $past(link_in_l0)) == '0) else $error("retrain in L0");
endmodule
bind pm_fence pm_fence_sva chk_u (.*);
`default_nettype wire

// ===== verification/pm_link_partner.sv
// Link partner model: acknowledges turn-off, drops and rewakes links
`timescale 1ns/10ps
`default_nettype none
module pm_link_partner
    import pm_fence_pkg::*;
(
    input wire logic          core_clk,
    input wire logic          rst,
    input wire logic          slow,
    input wire logic [NP-1:0] mute,
    input wire logic [NP-1:0] tx_turnoff,
    input wire logic [NP-1:0] retrain_req,
    output logic     [NP-1:0] rx_to_ack,
    output logic     [NP-1:0] link_in_l0
);
    // ****
    // Partner
    // ****
    int ack_cnt [NP];
    int wake_cnt [NP];
    always_ff @(posedge core_clk)
        for (int p = 0; p < NP; p++)
        begin
            rx_to_ack[p] <= ack_cnt[p] == 1;
            if (ack_cnt[p] == 1)
                link_in_l0[p] <= 1'h0;
            if (wake_cnt[p] == 1)
                link_in_l0[p] <= 1'h1;
            ack_cnt[p] <= (tx_turnoff[p] && !mute[p]) ? (slow ? 40 : 3) : ack_cnt[p] - (ack_cnt[p] != 0);
            wake_cnt[p] <= retrain_req[p] ? 5 : wake_cnt[p] - (wake_cnt[p] != 0);
            if (rst)
            begin
                ack_cnt[p] <= 0;
                wake_cnt[p] <= 0;
                link_in_l0[p] <= 1'h1;
            end
        end
endmodule
`default_nettype wire
